// ### rtl/pxs_delay_if.sv
// Signals between the pixel logic and its adjustable delay line.
`timescale 1ns/1ps
interface pxs_delay_if;
   logic [pxs_pkg::DATA_W-1:0] wr_data;
   logic [pxs_pkg::LAT_W-1:0] latency;
   logic [pxs_pkg::DATA_W-1:0] rd_data;
   modport owner (output wr_data, output latency, input rd_data);
   modport line (input wr_data, input latency, output rd_data);
endinterface : pxs_delay_if

// ### rtl/pxs_delay_line.sv
// Pixel delay line: a small memory with a movable read tap and registered output.
`timescale 1ns/1ps
module pxs_delay_line (
   input wire logic clk,
   input wire logic rst_n,
   pxs_delay_if.line dl
);
   typedef struct packed {
      logic [pxs_pkg::LINE_AW-1:0] ptr;
      logic [pxs_pkg::DATA_W-1:0] rd;
   } pxs_dl_t;

   logic [pxs_pkg::DATA_W-1:0] mem [pxs_pkg::LINE_DEPTH];
   pxs_dl_t st_r;
   pxs_dl_t st_nxt;
   logic [pxs_pkg::LINE_AW-1:0] rd_addr;

   // Registered read and the output register in the top add a cycle each, so the tap sits latency minus two behind.
   always_comb begin
      rd_addr = st_r.ptr - (dl.latency - pxs_pkg::LAT_W'(2));
      st_nxt = st_r;
      st_nxt.ptr = st_r.ptr + pxs_pkg::LINE_AW'(1);
      st_nxt.rd = mem[rd_addr];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Storage has no reset; stale contents only reach the output before fill.
   always_ff @(posedge clk) begin
      mem[st_r.ptr] <= dl.wr_data;
   end

   assign dl.rd_data = st_r.rd;
endmodule : pxs_delay_line

// ### rtl/pxs_pkg.sv
// Constants shared by the pixel sync and signature block.
package pxs_pkg;
   localparam int unsigned DATA_W = 24;
   localparam int unsigned LAT_W = 4;
   localparam logic [LAT_W-1:0] LAT_FIXED = 4'h8;
   localparam logic [LAT_W-1:0] LAT_MIN = 4'h6;
   localparam logic [LAT_W-1:0] LAT_MAX = 4'ha;
   localparam logic [LAT_W-1:0] LAT_POWERUP = 4'h6;
   localparam logic [1:0] STOP_EDGES = 2'h3;
   localparam logic [3:0] BLANK_SAFE = 4'hf;
   localparam logic [2:0] PHASE_LAST = 3'h7;
   localparam int unsigned LINE_DEPTH = 16;
   localparam int unsigned LINE_AW = 4;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_SIG = 8'h08;
   localparam int unsigned CTRL_PHSEL_LSB = 0;
   localparam int unsigned CTRL_MODE_BIT = 3;
   localparam int unsigned ST_ALIGNED_BIT = 0;
   localparam int unsigned ST_ARMED_BIT = 1;
   localparam logic [2:0] CTRL_PHSEL_RST = 3'h0;
   localparam logic CTRL_MODE_RST = 1'b0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
endpackage : pxs_pkg

// ### rtl/pxs_top.sv
// Pixel pipeline alignment and signature capture with an AHB-Lite register port.
// How it works
// R1: The clock source makes the load strobe as pixel clock divided by eight.
// R2: Load strobe is accepted at any phase; group phase restarts on its edge.
// R3: The far side may use the load strobe for shift clock and video timing.
// R4: Without alignment the pipeline latency is fixed somewhere from six to ten.
// R5: Clock held high, complement low over three strobe rises arms alignment.
// R6: Stopped clock may last any time; no timeout touches detection.
// R7: Restart puts the first falling clock edge near the rising strobe edge.
// R8: Software writes configuration first, then performs the alignment sequence.
// R9: Alignment never clears the blink counter.
// R10: Parallel devices should blink through read mask, not blink mask.
// R11: After alignment the latency is forced to eight cycles.
// R12: Each pixel goes to both the converter output and the accumulators.
// R13: Accumulators form a 24-bit shift register with feedback.
// R14: Exactly one pixel per load group is captured.
// R15: A three-bit phase select picks which of eight phases is captured.
// R16: Updates only in active display; access only 15 clocks into blanking. Strobe mode takes the read snapshot at any time, active display included.
// R17: Strobe mode holds the selected colour and ignores seed writes.
// R18: While alignment is armed, capture and accumulator updates are suppressed; seed loads still reach the accumulator.
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module pxs_top #(
   parameter int unsigned BLINK_W = 5
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic pixel_clk,
   input wire logic pixel_clk_n,
   input wire logic pixel_load_strobe_n,
   input wire logic blank_n,
   input wire logic [pxs_pkg::DATA_W-1:0] palette_data,
   output logic [pxs_pkg::DATA_W-1:0] pixel_out,
   output logic blink_state
);
   typedef struct packed {
      logic pc_s1;
      logic pc_s2;
      logic pcn_s1;
      logic pcn_s2;
      logic ld_s1;
      logic ld_s2;
      logic ld_prev;
      logic [1:0] stop_cnt;
      logic arm;
      logic ack_s1;
      logic ack_s2;
      logic aligned;
      logic sreq_s1;
      logic sreq_s2;
      logic sack;
      logic [pxs_pkg::DATA_W-1:0] sig;
      logic [pxs_pkg::DATA_W-1:0] seed;
      logic seed_tog;
      logic [2:0] phsel;
      logic mode;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic hready_o;
      logic hresp_o;
      logic [31:0] hrdata_o;
   } pxs_hc_t;

   typedef struct packed {
      logic ld_s1;
      logic ld_s2;
      logic ld_prev;
      logic blank_s1;
      logic blank_s2;
      logic [2:0] phsel_s1;
      logic [2:0] phsel_s2;
      logic mode_s1;
      logic mode_s2;
      logic arm_s1;
      logic arm_s2;
      logic arm_prev;
      logic seed_s1;
      logic seed_s2;
      logic seed_prev;
      logic sack_s1;
      logic sack_s2;
      logic [2:0] phase;
      logic [pxs_pkg::LAT_W-1:0] latency;
      logic aligned;
      logic [3:0] blank_cnt;
      logic [pxs_pkg::DATA_W-1:0] acc;
      logic [pxs_pkg::DATA_W-1:0] snap;
      logic snap_req;
      logic [BLINK_W-1:0] blink;
      logic [pxs_pkg::DATA_W-1:0] pix_out;
   } pxs_px_t;

   pxs_hc_t hc_r;
   pxs_hc_t hc_nxt;
   pxs_px_t px_r;
   pxs_px_t px_nxt;
   pxs_delay_if dly ();
   logic ld_rise_h;
   logic clk_stopped;
   logic addr_ok;
   logic cap;
   logic seed_ld;
   logic blank_safe;
   logic [pxs_pkg::DATA_W-1:0] lfsr_next;

   pxs_delay_line u_line (
      .clk(pixel_clk),
      .rst_n(hresetn),
      .dl(dly.line)
   );

   // Stop detection runs on hclk because the pixel clock itself stands still.
   assign ld_rise_h = hc_r.ld_s2 && !hc_r.ld_prev;
   assign clk_stopped = hc_r.pc_s2 && !hc_r.pcn_s2;
   assign addr_ok = hsel && htrans == pxs_pkg::HTRANS_NONSEQ && hready;

   always_comb begin
      hc_nxt = hc_r;
      hc_nxt.pc_s1 = pixel_clk;
      hc_nxt.pc_s2 = hc_r.pc_s1;
      hc_nxt.pcn_s1 = pixel_clk_n;
      hc_nxt.pcn_s2 = hc_r.pcn_s1;
      hc_nxt.ld_s1 = pixel_load_strobe_n;
      hc_nxt.ld_s2 = hc_r.ld_s1;
      hc_nxt.ld_prev = hc_r.ld_s2;
      hc_nxt.ack_s1 = px_r.arm_s2;
      hc_nxt.ack_s2 = hc_r.ack_s1;
      hc_nxt.sreq_s1 = px_r.snap_req;
      hc_nxt.sreq_s2 = hc_r.sreq_s1;
      if (!clk_stopped) begin
         hc_nxt.stop_cnt = 2'h0;
      end else if (ld_rise_h && hc_r.stop_cnt != pxs_pkg::STOP_EDGES) begin
         hc_nxt.stop_cnt = hc_r.stop_cnt + 2'h1; // [R5]
      end
      // No timeout: the armed level stays until the pixel side echoes it.
      if (hc_r.arm && hc_r.ack_s2) begin
         hc_nxt.arm = 1'b0;
         hc_nxt.aligned = 1'b1;
      end else if (hc_r.stop_cnt == pxs_pkg::STOP_EDGES && !hc_r.ack_s2) begin
         hc_nxt.arm = 1'b1; // [R5] [R6]
      end
      if (hc_r.sreq_s2 != hc_r.sack) begin
         hc_nxt.sig = px_r.snap;
         hc_nxt.sack = hc_r.sreq_s2;
      end
      hc_nxt.wr_pend = addr_ok && hwrite;
      hc_nxt.wr_addr = haddr[7:0];
      if (hc_r.wr_pend) begin
         unique case (hc_r.wr_addr)
            pxs_pkg::OFF_CTRL: begin
               hc_nxt.phsel = hwdata[pxs_pkg::CTRL_PHSEL_LSB +: 3]; // [R15]
               hc_nxt.mode = hwdata[pxs_pkg::CTRL_MODE_BIT]; // [R17]
            end
            pxs_pkg::OFF_SIG: begin
               hc_nxt.seed = hwdata[pxs_pkg::DATA_W-1:0];
               hc_nxt.seed_tog = !hc_r.seed_tog;
            end
            default: begin
               hc_nxt.wr_pend = hc_nxt.wr_pend;
            end
         endcase
      end
      if (addr_ok && !hwrite) begin
         hc_nxt.hrdata_o = 32'h0;
         unique case (haddr[7:0])
            pxs_pkg::OFF_CTRL: begin
               hc_nxt.hrdata_o[pxs_pkg::CTRL_PHSEL_LSB +: 3] = hc_r.phsel;
               hc_nxt.hrdata_o[pxs_pkg::CTRL_MODE_BIT] = hc_r.mode;
            end
            pxs_pkg::OFF_STATUS: begin
               hc_nxt.hrdata_o[pxs_pkg::ST_ALIGNED_BIT] = hc_r.aligned;
               hc_nxt.hrdata_o[pxs_pkg::ST_ARMED_BIT] = hc_r.arm;
            end
            pxs_pkg::OFF_SIG: begin
               hc_nxt.hrdata_o[pxs_pkg::DATA_W-1:0] = hc_r.sig; // [R16]
            end
            default: begin
               hc_nxt.hrdata_o = 32'h0;
            end
         endcase
      end
      hc_nxt.hready_o = 1'b1;
      hc_nxt.hresp_o = pxs_pkg::HRESP_OKAY;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hc_r <= '0;
         hc_r.phsel <= pxs_pkg::CTRL_PHSEL_RST;
         hc_r.mode <= pxs_pkg::CTRL_MODE_RST;
         hc_r.hready_o <= 1'b1;
      end else begin
         hc_r <= hc_nxt;
      end
   end

   assign hreadyout = hc_r.hready_o;
   assign hresp = hc_r.hresp_o;
   assign hrdata = hc_r.hrdata_o;

   // Pixel side: group phase counts from the synchronised strobe rise.
   assign blank_safe = px_r.blank_cnt == pxs_pkg::BLANK_SAFE;
   assign cap = px_r.phase == px_r.phsel_s2 && px_r.blank_s2 && !px_r.arm_s2; // [R14] [R18]
   assign seed_ld = px_r.seed_s2 != px_r.seed_prev && blank_safe && !px_r.mode_s2;
   assign lfsr_next = {px_r.acc[pxs_pkg::DATA_W-2:0], px_r.acc[pxs_pkg::DATA_W-1]}
      ^ dly.rd_data; // [R13]
   assign dly.wr_data = palette_data;
   assign dly.latency = px_r.latency;

   always_comb begin
      px_nxt = px_r;
      px_nxt.ld_s1 = pixel_load_strobe_n;
      px_nxt.ld_s2 = px_r.ld_s1;
      px_nxt.ld_prev = px_r.ld_s2;
      px_nxt.blank_s1 = blank_n;
      px_nxt.blank_s2 = px_r.blank_s1;
      px_nxt.phsel_s1 = hc_r.phsel;
      px_nxt.phsel_s2 = px_r.phsel_s1;
      px_nxt.mode_s1 = hc_r.mode;
      px_nxt.mode_s2 = px_r.mode_s1;
      px_nxt.arm_s1 = hc_r.arm;
      px_nxt.arm_s2 = px_r.arm_s1;
      px_nxt.arm_prev = px_r.arm_s2;
      px_nxt.seed_s1 = hc_r.seed_tog;
      px_nxt.seed_s2 = px_r.seed_s1;
      px_nxt.seed_prev = px_r.seed_s2;
      px_nxt.sack_s1 = hc_r.sack;
      px_nxt.sack_s2 = px_r.sack_s1;
      if (px_r.ld_s2 && !px_r.ld_prev) begin
         px_nxt.phase = 3'h0; // [R2]
         px_nxt.blink = px_r.blink + BLINK_W'(1); // [R9]
      end else begin
         px_nxt.phase = px_r.phase + 3'h1;
      end
      if (px_r.arm_s2 && !px_r.arm_prev) begin
         px_nxt.latency = pxs_pkg::LAT_FIXED; // [R11]
         px_nxt.aligned = 1'b1;
      end
      if (px_r.blank_s2) begin
         px_nxt.blank_cnt = 4'h0;
      end else if (!blank_safe) begin
         px_nxt.blank_cnt = px_r.blank_cnt + 4'h1; // [R16]
      end
      // Seed writes outside the safe blanking window are dropped silently.
      if (seed_ld) begin
         px_nxt.acc = hc_r.seed; // [R16] [R17]
      end else if (cap) begin
         px_nxt.acc = px_r.mode_s2 ? dly.rd_data : lfsr_next; // [R12] [R17]
      end
      if ((blank_safe || px_r.mode_s2) && px_r.snap_req == px_r.sack_s2) begin
         px_nxt.snap = px_r.acc;
         px_nxt.snap_req = !px_r.snap_req;
      end
      px_nxt.pix_out = dly.rd_data; // [R12]
   end

   always_ff @(posedge pixel_clk or negedge hresetn) begin
      if (!hresetn) begin
         px_r <= '0;
         px_r.latency <= pxs_pkg::LAT_POWERUP; // [R4]
      end else begin
         px_r <= px_nxt;
      end
   end

   assign pixel_out = px_r.pix_out;
   assign blink_state = px_r.blink[BLINK_W-1];

   property p_phase_restart;
      @(posedge pixel_clk) disable iff (!hresetn)
      (px_r.ld_s2 && !px_r.ld_prev) |=> px_r.phase == 3'h0;
   endproperty
   a_phase_restart: assert property (p_phase_restart) // [R2]
      else $error("group phase did not restart on strobe rise");

   property p_latency_range;
      @(posedge pixel_clk) disable iff (!hresetn)
      !px_r.aligned |=> px_r.latency >= pxs_pkg::LAT_MIN && px_r.latency <= pxs_pkg::LAT_MAX
         && px_r.latency == $past(px_r.latency) || px_r.aligned;
   endproperty
   a_latency_range: assert property (p_latency_range) // [R4]
      else $error("unaligned latency moved or left six to ten");

   property p_arm_on_stop;
      @(posedge hclk) disable iff (!hresetn)
      (clk_stopped && hc_r.stop_cnt == 2'h2 && ld_rise_h && !hc_r.ack_s2)
         ##1 clk_stopped |=> hc_r.arm;
   endproperty
   a_arm_on_stop: assert property (p_arm_on_stop) // [R5]
      else $error("third strobe rise with stopped clock did not arm");

   property p_arm_holds;
      @(posedge hclk) disable iff (!hresetn)
      (hc_r.arm && !hc_r.ack_s2) |=> hc_r.arm;
   endproperty
   a_arm_holds: assert property (p_arm_holds) // [R6]
      else $error("armed alignment dropped without the pixel side echo");

   property p_blink_kept;
      @(posedge pixel_clk) disable iff (!hresetn)
      (px_r.arm_s2 && !px_r.arm_prev) |=> px_r.blink == $past(px_r.blink)
         || px_r.blink == $past(px_r.blink) + BLINK_W'(1);
   endproperty
   a_blink_kept: assert property (p_blink_kept) // [R9]
      else $error("blink counter disturbed by alignment");

   property p_aligned_eight;
      @(posedge pixel_clk) disable iff (!hresetn)
      px_r.aligned |-> px_r.latency == 4'h8;
   endproperty
   a_aligned_eight: assert property (p_aligned_eight) // [R11]
      else $error("aligned pipeline not at eight cycles");

   property p_lfsr_step;
      @(posedge pixel_clk) disable iff (!hresetn)
      (cap && !seed_ld && !px_r.mode_s2) |=>
         px_r.acc == ({$past(px_r.acc[22:0]), $past(px_r.acc[23])} ^ $past(dly.rd_data));
   endproperty
   a_lfsr_step: assert property (p_lfsr_step) // [R13]
      else $error("signature step wrong");

   property p_one_per_group;
      @(posedge pixel_clk) disable iff (!hresetn)
      (cap && !(px_r.ld_s2 && !px_r.ld_prev)) |=> !cap [*6];
   endproperty
   a_one_per_group: assert property (p_one_per_group) // [R14]
      else $error("more than one capture in a load group");

   property p_phase_match;
      @(posedge pixel_clk) disable iff (!hresetn)
      cap |-> px_r.phase == px_r.phsel_s2;
   endproperty
   a_phase_match: assert property (p_phase_match) // [R15]
      else $error("capture on an unselected phase");

   property p_blank_hold;
      @(posedge pixel_clk) disable iff (!hresetn)
      (!px_r.blank_s2 && !seed_ld) |=> $stable(px_r.acc);
   endproperty
   a_blank_hold: assert property (p_blank_hold) // [R16]
      else $error("accumulator changed during blanking");

   property p_strobe_hold;
      @(posedge pixel_clk) disable iff (!hresetn)
      (cap && px_r.mode_s2) |=> px_r.acc == $past(dly.rd_data);
   endproperty
   a_strobe_hold: assert property (p_strobe_hold) // [R17] [R12]
      else $error("strobe mode did not hold the selected colour");

   property p_suppress;
      @(posedge pixel_clk) disable iff (!hresetn)
      (px_r.arm_s2 && !seed_ld) |=> $stable(px_r.acc);
   endproperty
   a_suppress: assert property (p_suppress) // [R18]
      else $error("accumulator updated while alignment armed");

   c_aligned: cover property (@(posedge hclk) disable iff (!hresetn) $rose(hc_r.aligned));
   c_seed: cover property (@(posedge pixel_clk) disable iff (!hresetn) seed_ld);
   c_capture: cover property (@(posedge pixel_clk) disable iff (!hresetn)
      cap && px_r.mode_s2);
   c_snapshot: cover property (@(posedge hclk) disable iff (!hresetn)
      hc_r.sreq_s2 != hc_r.sack);
endmodule : pxs_top

// ### tb/pxs_clk_gen.sv
// Behavioural clock source: pixel clock, divided load strobe and a palette stream.
`timescale 1ns/1ps
module pxs_clk_gen (
   output logic pixel_clk,
   output logic pixel_clk_n,
   output logic pixel_load_strobe_n,
   output logic [pxs_pkg::DATA_W-1:0] palette_data,
   input wire logic stop,
   input wire logic pal_fixed,
   input wire logic [pxs_pkg::DATA_W-1:0] pal_val
);
   assign pixel_clk_n = ~pixel_clk;
   initial begin
      pixel_clk = 1'b1;
      pixel_load_strobe_n = 1'b1;
      palette_data = '0;
      #7;
      forever begin
         // The strobe edge lands on a clock fall, one of the phases the device must take.
         for (int i = 0; i < 8; i++) begin
            pixel_load_strobe_n = (i < 4);
            pixel_clk = 1'b0;
            #15;
            pixel_clk = 1'b1;
            #15;
         end
         // Clock stays high while the strobe keeps running on its own timer.
         while (stop) begin
            #120;
            pixel_load_strobe_n = 1'b0;
            #120;
            pixel_load_strobe_n = 1'b1;
         end
         // Leaving here puts the first clock fall exactly on the strobe rise.
      end
   end
   always @(posedge pixel_clk) begin
      palette_data <= pal_fixed ? pal_val : palette_data + 1'b1;
   end
endmodule : pxs_clk_gen

// ### tb/testbench.sv
// Self-checking bench for pipeline alignment and signature capture.
`timescale 1ns/1ps
module testbench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, blink_state;
   logic [31:0] haddr, hwdata, hrdata, rd, q0;
   logic [1:0] htrans;
   logic pixel_clk, pixel_clk_n, pixel_load_strobe_n, blank_n, stop, pal_fixed, ok;
   logic [pxs_pkg::DATA_W-1:0] palette_data, pixel_out, pal_val;
   logic [2:0] base;
   int n;
   int mismatches = 0;
   int checks_done = 0;
   pxs_clk_gen u_gen (.pixel_clk(pixel_clk), .pixel_clk_n(pixel_clk_n),
      .pixel_load_strobe_n(pixel_load_strobe_n), .palette_data(palette_data),
      .stop(stop), .pal_fixed(pal_fixed), .pal_val(pal_val));
   pxs_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pixel_clk(pixel_clk), .pixel_clk_n(pixel_clk_n),
      .pixel_load_strobe_n(pixel_load_strobe_n), .blank_n(blank_n),
      .palette_data(palette_data), .pixel_out(pixel_out), .blink_state(blink_state));
   task automatic end_of_test;
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= pxs_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      check(what, rd, exp);
      check("hresp", {31'h0, hresp}, {31'h0, pxs_pkg::HRESP_OKAY});
   endtask : rd_chk
   // Pixel output is compared with the live palette count, so the gap is the latency.
   // Sampling on the falling edge keeps the look away from the edge that updates both.
   task automatic lat_check(input logic [pxs_pkg::LAT_W-1:0] lat, input string what);
      repeat (4) begin
         @(negedge pixel_clk);
         check(what, {8'h0, palette_data - pixel_out}, {28'h0, lat});
      end
   endtask : lat_check
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      blank_n = 1'b0;
      stop = 1'b0;
      pal_fixed = 1'b0;
      pal_val = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(pxs_pkg::OFF_CTRL, 32'h0, "ctrl reset");
      rd_chk(pxs_pkg::OFF_STATUS, 32'h0, "status reset");
      bus(1'b1, 8'h0c, 32'hffffffff);
      rd_chk(8'h0c, 32'h0, "unmapped");
      bus(1'b1, pxs_pkg::OFF_CTRL, 32'hd);
      rd_chk(pxs_pkg::OFF_CTRL, 32'hd, "ctrl readback");
      bus(1'b1, pxs_pkg::OFF_CTRL, 32'h0);
      lat_check(pxs_pkg::LAT_POWERUP, "latency power-up");
      @(posedge hclk);
      stop <= 1'b1;
      repeat (2) @(posedge pixel_load_strobe_n);
      rd_chk(pxs_pkg::OFF_STATUS, 32'h0, "armed too early");
      repeat (4) @(posedge pixel_load_strobe_n);
      rd_chk(pxs_pkg::OFF_STATUS, 32'h2, "armed");
      repeat (6) @(posedge pixel_load_strobe_n);
      rd_chk(pxs_pkg::OFF_STATUS, 32'h2, "armed long stop");
      stop <= 1'b0;
      repeat (40) @(posedge pixel_clk);
      rd_chk(pxs_pkg::OFF_STATUS, 32'h1, "aligned");
      lat_check(pxs_pkg::LAT_FIXED, "latency aligned");
      // The blink counter keeps running after alignment; its top bit flips every 16 groups.
      ok = blink_state;
      repeat (16) @(posedge pixel_load_strobe_n);
      check("blink", {31'h0, blink_state}, {31'h0, ~ok});
      // Zero pixels make each capture a pure rotation, so the seed bit counts groups.
      @(posedge hclk);
      pal_fixed <= 1'b1;
      repeat (60) @(posedge hclk);
      bus(1'b1, pxs_pkg::OFF_SIG, 32'h1);
      repeat (40) @(posedge hclk);
      rd_chk(pxs_pkg::OFF_SIG, 32'h1, "seed");
      blank_n <= 1'b1;
      n = 0;
      repeat (20) begin
         @(posedge pixel_load_strobe_n);
         n++;
      end
      @(posedge hclk);
      blank_n <= 1'b0;
      repeat (80) @(posedge hclk);
      bus(1'b0, pxs_pkg::OFF_SIG, 32'h0);
      ok = 1'b0;
      for (int k = n - 2; k <= n + 2; k++) begin
         if (rd === (32'h1 << k)) begin
            ok = 1'b1;
         end
      end
      check("signature", {31'h0, ok}, 32'h1);
      q0 = rd;
      repeat (100) @(posedge hclk);
      rd_chk(pxs_pkg::OFF_SIG, q0, "hold in blanking");
      @(posedge hclk);
      pal_val <= 24'h5a3c1e;
      blank_n <= 1'b1;
      bus(1'b1, pxs_pkg::OFF_CTRL, 32'h8);
      repeat (100) @(posedge hclk);
      rd_chk(pxs_pkg::OFF_SIG, 32'h5a3c1e, "strobe capture");
      blank_n <= 1'b0;
      repeat (60) @(posedge hclk);
      bus(1'b1, pxs_pkg::OFF_SIG, 32'h123456);
      repeat (40) @(posedge hclk);
      rd_chk(pxs_pkg::OFF_SIG, 32'h5a3c1e, "seed ignored");
      // Counting pixels make the captured low bits follow the selected phase.
      pal_fixed <= 1'b0;
      blank_n <= 1'b1;
      // The phase is changed while blanked, so no group sees two captures.
      for (int p = 0; p < 8; p++) begin
         blank_n <= 1'b0;
         bus(1'b1, pxs_pkg::OFF_CTRL, 32'h8 | 32'(p));
         repeat (30) @(posedge hclk);
         blank_n <= 1'b1;
         repeat (60) @(posedge hclk);
         bus(1'b0, pxs_pkg::OFF_SIG, 32'h0);
         if (p == 0) begin
            base = rd[2:0];
         end
         check("phase select", {29'h0, rd[2:0] - base}, 32'(p));
      end
      end_of_test();
   end
endmodule : testbench
